// ==== logic/gbg_pkg.sv ====
// constants for the gateway board glue: register map, reset values
// assumes a plain strobe register port on a single 25 MHz clock
package gbg_pkg;

  // ****************************************************************
  // register map, byte addresses of aligned words
  // ****************************************************************
  localparam logic [7:0] GBG_ADDR_CTRL = 8'h00; // control bits
  localparam logic [7:0] GBG_ADDR_STAT = 8'h04; // sensed levels
  localparam logic [7:0] GBG_ADDR_ID = 8'h08; // block id

  // ****************************************************************
  // control word field positions
  // ****************************************************************
  localparam int GBG_B_PU1 = 0; // input one pull-up enable
  localparam int GBG_B_PU2 = 1; // input two pull-up enable
  localparam int GBG_B_PU3 = 2; // input three pull-up enable
  localparam int GBG_B_RANGE = 3; // analog range select
  localparam int GBG_B_DRV3 = 4; // terminal three clamp
  localparam int GBG_B_PRED = 5; // red power led
  localparam int GBG_B_PGRN = 6; // green power led, active low
  localparam int GBG_B_PSRC = 7; // green power led source
  localparam int GBG_B_URED = 8; // red user led, active low
  localparam int GBG_B_UGRN = 9; // green user led, active low
  localparam int GBG_B_BIAS = 10; // antenna bias enable
  localparam int GBG_B_ETH = 11; // ethernet enable
  localparam int GBG_B_HOLD = 12; // power hold
  localparam int GBG_CTRL_W = 13; // control width

  // power-up control word: pu1, red, green-off, user-offs, bias,
  // ethernet and hold high; all else low
  localparam logic [12:0] GBG_CTRL_RST = 13'h1f61;

  // ****************************************************************
  // status word field positions
  // ****************************************************************
  localparam int GBG_S_IN1 = 0; // input one sense
  localparam int GBG_S_IN2 = 1; // input two sense
  localparam int GBG_S_IN3 = 2; // input three sense
  localparam int GBG_S_BTN = 3; // button sense
  localparam int GBG_S_ONOFF = 4; // on/off sense
  localparam int GBG_STAT_W = 5; // status width

  // arbitrary value, identifies nothing
  localparam logic [31:0] GBG_ID_VAL = 32'h0000_1234;
  localparam logic [31:0] GBG_ZERO = 32'h0000_0000;
  localparam int GBG_ADC_BITS = 15; // converter resolution

endpackage

// ==== logic/gbg_sense_if.sv ====
// bundle of synchronised field sense levels between glue modules
// assumes producer and consumer share clk_i
`timescale 1ns/1ps
interface gbg_sense_if;
  logic [4:0] lvl; // synchronised terminal levels, true polarity
  modport src (output lvl);
  modport dst (input lvl);
endinterface

// ==== logic/gbg_sync.sv ====
// two-flop synchroniser bank for the raw terminal levels
// assumes pins are asynchronous to clk_i
`timescale 1ns/1ps
module gbg_sync
  import gbg_pkg::*;
#(
  parameter int WIDTH = 5
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  gbg_sense_if.src sense
);

  // ****************************************************************
  // per-bit two stage synchroniser
  // ****************************************************************
  logic [WIDTH-1:0] meta_r; // first stage, read only by stage two
  logic [WIDTH-1:0] sync_r; // second stage

  generate
    for (genvar g = 0; g < WIDTH; g++) begin : g_bit
      // reset high: idle terminal pulled up reads high
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          meta_r[g] <= 1'b1;
          sync_r[g] <= 1'b1;
        end else begin
          meta_r[g] <= pin_i[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign sense.lvl = sync_r;

endmodule

// ==== logic/gbg_top.sv ====
// gateway board glue: field inputs, led drive, power control bits
// assumes a plain strobe register master on clk_i, async pins
// Function
// [RL1] field input senses read inverted terminal
// [RL2] input one pull-up, enabled at power-up
// [RL3] input two, three pull-ups start disabled
// [RL4] range select: low 0-5V, high 0-10V
// [RL5] drive high clamps terminal three low
// [RL6] button sense high released, low pressed
// [RL7] red power led active high, starts lit
// [RL8] green power led active low, starts off
// [RL9] source select: high control, low wan
// [RL10] user leds active low, start off
// [RL11] antenna bias enable high, starts on
// [RL12] ethernet enable high, default active
// [RL13] power hold high keeps unit powered
// [RL14] on/off sense inverts external line
// [RL15] firmware drops hold before turning off
// [RL16] controls take defaults, hold until written
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module gbg_top
  import gbg_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // field terminals and board inputs
  input wire logic field_input_one_i,
  input wire logic field_input_two_i,
  input wire logic field_terminal_three_i,
  input wire logic button_n_i,
  input wire logic onoff_line_i,
  input wire logic wan_activity_n_i,
  // board controls
  output logic input_one_pullup_en_o,
  output logic input_two_pullup_en_o,
  output logic input_three_pullup_en_o,
  output logic analog_range_sel_o,
  output logic terminal_three_o,
  output logic terminal_three_oe_o,
  output logic power_led_red_o,
  output logic power_led_green_n_o,
  output logic user_led_red_n_o,
  output logic user_led_green_n_o,
  output logic antenna_bias_en_o,
  output logic ethernet_en_o,
  output logic power_hold_o,
  output logic power_on_o
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  gbg_sense_if sense (); // synchronised terminal levels
  logic wan_m_r; // wan activity first stage
  logic wan_s_r; // wan activity second stage
  logic [GBG_STAT_W-1:0] stat_w; // sensed levels as firmware sees

  gbg_sync #(
    .WIDTH(GBG_STAT_W)
  ) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pin_i({onoff_line_i, button_n_i, field_terminal_three_i,
            field_input_two_i, field_input_one_i}),
    .sense(sense)
  );

  // wan activity is a board pin too, so it gets its own pair
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wan_m_r <= 1'b1;
      wan_s_r <= 1'b1;
    end else begin
      wan_m_r <= wan_activity_n_i;
      wan_s_r <= wan_m_r;
    end
  end

  // sense polarity: grounded terminal reads high
  always_comb begin
    stat_w[GBG_S_IN1] = ~sense.lvl[GBG_S_IN1]; // see RL1
    stat_w[GBG_S_IN2] = ~sense.lvl[GBG_S_IN2]; // see RL1
    stat_w[GBG_S_IN3] = ~sense.lvl[GBG_S_IN3]; // see RL1
    // button line idles high, pressing pulls it low
    stat_w[GBG_S_BTN] = sense.lvl[GBG_S_BTN]; // see RL6
    // low external on/off means off, reads as high
    stat_w[GBG_S_ONOFF] = ~sense.lvl[GBG_S_ONOFF]; // see RL14
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  logic [GBG_CTRL_W-1:0] ctrl_r; // firmware control bits
  logic wr_ctrl; // write to control word

  assign wr_ctrl = reg_wr_i && (reg_addr_i == GBG_ADDR_CTRL);

  // defaults at power-up, kept until written
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= GBG_CTRL_RST; // see RL16 RL2 RL3 RL4 RL7 RL8
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata_i[GBG_CTRL_W-1:0]; // see RL16
    end
  end

  // ****************************************************************
  // read path, data valid the cycle after the strobe only
  // ****************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= GBG_ZERO;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        GBG_ADDR_CTRL: begin
          reg_rdata_o <= {19'h0, ctrl_r};
        end
        GBG_ADDR_STAT: begin
          reg_rdata_o <= {27'h0, stat_w};
        end
        GBG_ADDR_ID: begin
          reg_rdata_o <= GBG_ID_VAL;
        end
        // unmapped reads return zero
        default: begin
          reg_rdata_o <= GBG_ZERO;
        end
      endcase
    end else begin
      // data stands one cycle only
      reg_rdata_o <= GBG_ZERO;
    end
  end

  // ****************************************************************
  // output drivers, all registered
  // ****************************************************************
  logic green_mux; // green power led after source select
  logic onoff_on; // external line says on

  // dedicated control when select high, wan activity otherwise
  assign green_mux = ctrl_r[GBG_B_PSRC] ? ctrl_r[GBG_B_PGRN]
                                        : wan_s_r; // see RL9
  assign onoff_on = sense.lvl[GBG_S_ONOFF];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      input_one_pullup_en_o <= 1'b1;
      input_two_pullup_en_o <= 1'b0;
      input_three_pullup_en_o <= 1'b0;
      analog_range_sel_o <= 1'b0;
      terminal_three_o <= 1'b0;
      terminal_three_oe_o <= 1'b0;
      power_led_red_o <= 1'b1;
      power_led_green_n_o <= 1'b1;
      user_led_red_n_o <= 1'b1;
      user_led_green_n_o <= 1'b1;
      antenna_bias_en_o <= 1'b1;
      ethernet_en_o <= 1'b1;
      power_hold_o <= 1'b1;
      power_on_o <= 1'b1;
    end else begin
      input_one_pullup_en_o <= ctrl_r[GBG_B_PU1]; // see RL2
      input_two_pullup_en_o <= ctrl_r[GBG_B_PU2]; // see RL3
      input_three_pullup_en_o <= ctrl_r[GBG_B_PU3]; // see RL3
      analog_range_sel_o <= ctrl_r[GBG_B_RANGE]; // see RL4
      // open drain: drive low when clamped, else float
      terminal_three_o <= 1'b0; // see RL5
      terminal_three_oe_o <= ctrl_r[GBG_B_DRV3]; // see RL5
      power_led_red_o <= ctrl_r[GBG_B_PRED]; // see RL7
      power_led_green_n_o <= green_mux; // see RL8
      user_led_red_n_o <= ctrl_r[GBG_B_URED]; // see RL10
      user_led_green_n_o <= ctrl_r[GBG_B_UGRN]; // see RL10
      antenna_bias_en_o <= ctrl_r[GBG_B_BIAS]; // see RL11
      ethernet_en_o <= ctrl_r[GBG_B_ETH]; // see RL12
      power_hold_o <= ctrl_r[GBG_B_HOLD]; // see RL13
      // hold keeps power whatever the line; firmware must drop it
      power_on_o <= ctrl_r[GBG_B_HOLD] | onoff_on; // see RL13 RL15
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_in_sense;
    @(posedge clk_i) disable iff (!arst_n_i)
    $fell(field_input_one_i) |-> ##3 stat_w[GBG_S_IN1];
  endproperty
  a_in_sense: assert property (p_in_sense) // see RL1
    else $error("input one sense not inverted");

  property p_btn;
    @(posedge clk_i) disable iff (!arst_n_i)
    $fell(button_n_i) ##1 !button_n_i [*2] |-> !stat_w[GBG_S_BTN];
  endproperty
  a_btn: assert property (p_btn) // see RL6
    else $error("button press not sensed");

  property p_onoff;
    @(posedge clk_i) disable iff (!arst_n_i)
    $rose(onoff_line_i) ##1 onoff_line_i [*2] |-> !stat_w[GBG_S_ONOFF];
  endproperty
  a_onoff: assert property (p_onoff) // see RL14
    else $error("on/off sense not inverted");

  property p_clamp;
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_ctrl ##1 1'b1 |=>
      terminal_three_oe_o == $past(reg_wdata_i[GBG_B_DRV3], 2)
      && !terminal_three_o;
  endproperty
  a_clamp: assert property (p_clamp) // see RL5
    else $error("terminal three clamp wrong");

  property p_green_src;
    @(posedge clk_i) disable iff (!arst_n_i)
    !ctrl_r[GBG_B_PSRC] |=> power_led_green_n_o == $past(wan_s_r);
  endproperty
  a_green_src: assert property (p_green_src) // see RL9
    else $error("green led not from wan activity");

  property p_hold;
    @(posedge clk_i) disable iff (!arst_n_i)
    ctrl_r[GBG_B_HOLD] |=> power_on_o;
  endproperty
  a_hold: assert property (p_hold) // see RL13
    else $error("power dropped under hold");

  property p_keep;
    @(posedge clk_i) disable iff (!arst_n_i)
    !wr_ctrl |=> $stable(ctrl_r);
  endproperty
  a_keep: assert property (p_keep) // see RL16
    else $error("control changed without write");

  property p_led;
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_ctrl ##1 !wr_ctrl |=>
      user_led_red_n_o == $past(reg_wdata_i[GBG_B_URED], 2)
      && power_led_red_o == $past(reg_wdata_i[GBG_B_PRED], 2);
  endproperty
  a_led: assert property (p_led) // see RL7 RL10
    else $error("led drive does not follow write");

  // ****************************************************************
  // more assertions: sense, pull-ups, range, enables, power release
  // ****************************************************************
  // terminal two shares the inverted sense of input one
  property p_in2_sense;
    @(posedge clk_i) disable iff (!arst_n_i)
    $rose(field_input_two_i) ##1 field_input_two_i [*2]
      |-> !stat_w[GBG_S_IN2];
  endproperty
  a_in2_sense: assert property (p_in2_sense) // see RL1
    else $error("input two sense not inverted");

  // a grounded terminal three reads high, clamped or driven from afar
  property p_in3_sense;
    @(posedge clk_i) disable iff (!arst_n_i)
    $fell(field_terminal_three_i) ##1 !field_terminal_three_i [*2]
      |-> stat_w[GBG_S_IN3];
  endproperty
  a_in3_sense: assert property (p_in3_sense) // see RL1
    else $error("input three sense not inverted");

  // pull-up enables land two edges after the write strobe
  property p_pullups;
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_ctrl ##1 1'b1 |=>
      input_one_pullup_en_o == $past(reg_wdata_i[GBG_B_PU1], 2)
      && input_two_pullup_en_o == $past(reg_wdata_i[GBG_B_PU2], 2)
      && input_three_pullup_en_o == $past(reg_wdata_i[GBG_B_PU3], 2);
  endproperty
  a_pullups: assert property (p_pullups) // see RL2 RL3
    else $error("pull-up enable does not follow write");

  // range select reaches the converter front end unchanged
  property p_range;
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_ctrl ##1 1'b1 |=>
      analog_range_sel_o == $past(reg_wdata_i[GBG_B_RANGE], 2);
  endproperty
  a_range: assert property (p_range) // see RL4
    else $error("range select does not follow write");

  // bias, ethernet and hold are plain active-high copies
  property p_enables;
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_ctrl ##1 1'b1 |=>
      antenna_bias_en_o == $past(reg_wdata_i[GBG_B_BIAS], 2)
      && ethernet_en_o == $past(reg_wdata_i[GBG_B_ETH], 2)
      && power_hold_o == $past(reg_wdata_i[GBG_B_HOLD], 2);
  endproperty
  a_enables: assert property (p_enables) // see RL11 RL12 RL13
    else $error("enable does not follow write");

  // with select high the dedicated active-low bit drives green
  property p_green_own;
    @(posedge clk_i) disable iff (!arst_n_i)
    ctrl_r[GBG_B_PSRC] |=>
      power_led_green_n_o == $past(ctrl_r[GBG_B_PGRN]);
  endproperty
  a_green_own: assert property (p_green_own) // see RL8 RL9
    else $error("green led not from its own control");

  // user green led, active low like user red
  property p_user_green;
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_ctrl ##1 1'b1 |=>
      user_led_green_n_o == $past(reg_wdata_i[GBG_B_UGRN], 2);
  endproperty
  a_user_green: assert property (p_user_green) // see RL10
    else $error("user green led does not follow write");

  // hold released: the external line alone decides power
  property p_release;
    @(posedge clk_i) disable iff (!arst_n_i)
    !ctrl_r[GBG_B_HOLD] |=> power_on_o == $past(onoff_on);
  endproperty
  a_release: assert property (p_release) // see RL13 RL14
    else $error("power does not follow line when released");

endmodule

// ==== testbench/gbg_field_model.sv ====
// field side model: terminals, button, on/off line and wan activity
// assumes the bench picks far-end levels; the clamp acts on the wire
`timescale 1ns/1ps
module gbg_field_model (
  input wire logic [4:0] lvl_i, // far-end levels, order as status
  input wire logic wan_n_i, // wan activity, active low
  input wire logic clamp_val_i, // level the clamp forces
  input wire logic clamp_oe_i, // clamp engaged
  output logic [4:0] pin_o, // resolved terminal levels
  output logic wan_n_o // wan line toward the block
);
  // ****************************************************************
  // wire resolution
  // ****************************************************************
  // terminal three is shared: an engaged clamp beats the far source
  always_comb begin
    pin_o = lvl_i;
    if (clamp_oe_i) begin
      pin_o[2] = clamp_val_i;
    end
  end
  // wan source has no pull, passed straight through
  assign wan_n_o = wan_n_i;
endmodule

// ==== testbench/gbg_top_tb.sv ====
// self-checking bench for the gateway board glue
// assumes gbg_top on one 25 MHz clock and the field model beside it
`timescale 1ns/1ps
`define GBG_CHK(nm, exp, got) begin checked++; \
  if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, exp, got); end end
module gbg_top_tb;
  import gbg_pkg::*;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [4:0] lvl = 5'h1f; // on, released, terminals high
  logic wan_n = 1'b1; // wan idle
  logic [4:0] pin;
  logic wan_n_w;
  logic pu1, pu2, pu3, rng, t3, t3_oe, pred, pgrn_n, ured_n, ugrn_n;
  logic bias, eth, hold, pwr_on;
  int checked = 0;
  int error_cnt = 0;
  always #20 clk_i = ~clk_i;
  gbg_top u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .field_input_one_i(pin[0]), .field_input_two_i(pin[1]),
    .field_terminal_three_i(pin[2]), .button_n_i(pin[3]),
    .onoff_line_i(pin[4]), .wan_activity_n_i(wan_n_w),
    .input_one_pullup_en_o(pu1), .input_two_pullup_en_o(pu2),
    .input_three_pullup_en_o(pu3), .analog_range_sel_o(rng),
    .terminal_three_o(t3), .terminal_three_oe_o(t3_oe),
    .power_led_red_o(pred), .power_led_green_n_o(pgrn_n),
    .user_led_red_n_o(ured_n), .user_led_green_n_o(ugrn_n),
    .antenna_bias_en_o(bias), .ethernet_en_o(eth),
    .power_hold_o(hold), .power_on_o(pwr_on));
  gbg_field_model u_field (.lvl_i(lvl), .wan_n_i(wan_n),
    .clamp_val_i(t3), .clamp_oe_i(t3_oe), .pin_o(pin), .wan_n_o(wan_n_w));
  // ****************************************************************
  // helpers
  // ****************************************************************
  // outputs packed in control word order; source select has no pin
  function automatic logic [12:0] obs(input logic b7);
    return {hold, eth, bias, ugrn_n, ured_n, b7, pgrn_n, pred, t3_oe,
            rng, pu3, pu2, pu1};
  endfunction
  task settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task do_reset;
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task chk_defaults;
    logic [31:0] d;
    #1;
    `GBG_CHK("outs", GBG_CTRL_RST, obs(1'b0))
    `GBG_CHK("outs2", GBG_CTRL_RST, obs(1'b0))
    `GBG_CHK("clamp val", 1'b0, t3)
    rd(GBG_ADDR_CTRL, d);
    `GBG_CHK("ctrl", {19'h0, GBG_CTRL_RST}, d)
    rd(GBG_ADDR_ID, d);
    `GBG_CHK("id", GBG_ID_VAL, d)
    rd(8'h0c, d);
    `GBG_CHK("unmapped", GBG_ZERO, d)
  endtask
  // each control bit alone, source select high so green follows bit 6
  task t_walk;
    logic [12:0] v;
    for (int i = 0; i < GBG_CTRL_W; i++) begin
      v = 13'h0080 | (13'h0001 << i);
      wr(GBG_ADDR_CTRL, {19'h0, v});
      settle(3);
      `GBG_CHK("walk", v, obs(1'b1))
      `GBG_CHK("walk2", v, obs(1'b1))
    end
    settle(20);
    `GBG_CHK("held", v, obs(1'b1))
  endtask
  // every level combination; button is the only true-polarity sense
  task t_sense;
    logic [31:0] d;
    wr(GBG_ADDR_CTRL, {19'h0, GBG_CTRL_RST});
    for (int p = 0; p < 32; p++) begin
      @(posedge clk_i) lvl <= p[4:0];
      settle(4);
      rd(GBG_ADDR_STAT, d);
      `GBG_CHK("stat", {27'h0, p[4:0] ^ 5'h17}, d)
    end
    @(posedge clk_i) lvl <= 5'h1f;
    wr(GBG_ADDR_CTRL, 32'h0000_0010);
    settle(6);
    rd(GBG_ADDR_STAT, d);
    `GBG_CHK("clamped", 1'b1, d[GBG_S_IN3])
  endtask
  task t_power;
    @(posedge clk_i) lvl <= 5'h0f;
    wr(GBG_ADDR_CTRL, {19'h0, GBG_CTRL_RST});
    settle(6);
    `GBG_CHK("held on", 1'b1, pwr_on)
    wr(GBG_ADDR_CTRL, 32'h0000_0f61); // hold dropped first
    settle(6);
    `GBG_CHK("off", 1'b0, pwr_on)
    @(posedge clk_i) lvl <= 5'h1f;
    wan_n <= 1'b0;
    settle(6);
    `GBG_CHK("line on", 1'b1, pwr_on)
    `GBG_CHK("wan lit", 1'b0, pgrn_n)
    @(posedge clk_i) wan_n <= 1'b1;
    settle(6);
    `GBG_CHK("wan dark", 1'b1, pgrn_n)
  endtask
  // ****************************************************************
  // sequence and hang guard
  // ****************************************************************
  initial begin
    do_reset();
    chk_defaults();
    t_walk();
    t_sense();
    t_power();
    do_reset();
    chk_defaults();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    complete_run();
  end
endmodule
